//--- verilog/tlhc_pkg.sv
// tlhc_pkg: offsets, field positions, reset values and encodings for the
// low-half timer control block.
// assumes a 32-bit apb with one register per aligned word.
package tlhc_pkg;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_TIMER_CONTROL = 8'h00;
   localparam logic [7:0] OFF_PERIOD        = 8'h04;
   localparam logic [7:0] OFF_COUNTER       = 8'h08;
   localparam logic [7:0] OFF_GLOBAL_MODE   = 8'h0c;

   // ----------------------------------------------------------------
   // timer_control field positions
   // ----------------------------------------------------------------
   localparam int BIT_UPPER_OUTPUT_STATE = 16;
   localparam int BIT_INPUT_GATE_ENABLE  = 9;
   localparam int BIT_CLOCK_SOURCE       = 8;
   localparam int BIT_ENABLING_MODE_HI   = 7;
   localparam int BIT_ENABLING_MODE_LO   = 6;
   localparam int BIT_PULSE_WIDTH_HI     = 5;
   localparam int BIT_PULSE_WIDTH_LO     = 4;
   localparam int BIT_CLOCK_PULSE        = 3;
   localparam int BIT_INPUT_INVERT       = 2;
   localparam int BIT_OUTPUT_INVERT      = 1;
   localparam int BIT_OUTPUT_STATE       = 0;

   // global mode register: operating mode sits in bits 3-2
   localparam int BIT_OPMODE_HI = 3;
   localparam int BIT_OPMODE_LO = 2;

   // ----------------------------------------------------------------
   // encodings and reset values
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      TLHC_EN_DISABLED   = 2'b00,
      TLHC_EN_ONE_SHOT   = 2'b01,
      TLHC_EN_CONTINUOUS = 2'b10,
      TLHC_EN_RESERVED   = 2'b11
   } tlhc_enable_t;

   localparam logic [1:0]  OPMODE_GP64     = 2'b00;
   localparam logic [1:0]  OPMODE_WATCHDOG = 2'b10;

   localparam logic [31:0] RESET_PERIOD  = 32'h0000_0000;
   localparam logic [31:0] RESET_COUNTER = 32'h0000_0000;
   localparam logic [1:0]  RESET_OPMODE  = 2'b00;
   localparam logic [31:0] READ_ZERO     = 32'h0000_0000;

endpackage

//--- verilog/tlhc_timer_low_half.sv
// tlhc_timer_low_half: control, counting and output shaping of the low
// timer half, with its registers on an apb slave.
// assumes the timer pin input may be asynchronous to clk and that the upper
// half supplies its output level on upperTimerOutput.
//
// Notes on behaviour
// - bit 16 reads upper half output level
// - bits 15-10 read zero, ignore writes
// - input gating only with internal clock
// - gate on synchronised high timer input
// - bit 8 picks internal or pin clock
// - mode 00 holds count; 11 is invalid
// - mode 01 runs once, stops at period
// - mode 10 wraps to zero after period
// - pulse width field gives 1 to 4 cycles
// - pulse mode emits pulse at period
// - clock mode toggles output at period
// - watchdog mode forces pulse mode
// - input invert acts only on pin clock
// - output invert bit inverts low output
// - bit 0 reads low output level
// - pin driven from status, optionally inverted
// - operating mode 00 selects 64-bit mode
//
// The APB register port and the register offsets were left to the implementer.
module tlhc_timer_low_half (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // timer pins and neighbours
   input  wire logic        timerInputPin,
   input  wire logic        upperTimerOutput,
   output logic             lowTimerOutputPin,
   output logic             gp64ModeSelect
);

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic        lowInputGateEnable;
   logic        lowClockSourceSelect;
   logic [1:0]  lowEnablingMode;
   logic [1:0]  lowPulseWidth;
   logic        lowClockPulseSelect;
   logic        lowInputInvert;
   logic        lowOutputInvert;
   logic        lowOutputState;
   logic        upperOutputState;
   logic [1:0]  timerOperatingMode;
   logic [31:0] period;
   logic [31:0] counter;

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   logic setupPhase;
   logic accessDone;
   logic writeDone;
   logic addrMapped;

   // unmapped offsets still answer, with pslverr, so a bad address never hangs the bus
   assign setupPhase = psel && !penable;
   assign accessDone = psel && penable && pready;
   assign writeDone  = accessDone && pwrite;
   assign addrMapped = (paddr == tlhc_pkg::OFF_TIMER_CONTROL) ||
                       (paddr == tlhc_pkg::OFF_PERIOD) ||
                       (paddr == tlhc_pkg::OFF_COUNTER) ||
                       (paddr == tlhc_pkg::OFF_GLOBAL_MODE);

   // ready comes one cycle after setup, so every transfer has one access cycle
   always_ff @(posedge clk) begin
      if (reset) begin
         pready <= 1'b0;
      end else begin
         pready <= setupPhase;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= setupPhase && !addrMapped;
      end
   end

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   logic [31:0] controlView;

   always_comb begin
      controlView = tlhc_pkg::READ_ZERO;
      controlView[tlhc_pkg::BIT_UPPER_OUTPUT_STATE] = upperOutputState;
      controlView[tlhc_pkg::BIT_INPUT_GATE_ENABLE]  = lowInputGateEnable;
      controlView[tlhc_pkg::BIT_CLOCK_SOURCE]       = lowClockSourceSelect;
      controlView[tlhc_pkg::BIT_ENABLING_MODE_HI:tlhc_pkg::BIT_ENABLING_MODE_LO] =
         lowEnablingMode;
      controlView[tlhc_pkg::BIT_PULSE_WIDTH_HI:tlhc_pkg::BIT_PULSE_WIDTH_LO] =
         lowPulseWidth;
      controlView[tlhc_pkg::BIT_CLOCK_PULSE]        = lowClockPulseSelect;
      controlView[tlhc_pkg::BIT_INPUT_INVERT]       = lowInputInvert;
      controlView[tlhc_pkg::BIT_OUTPUT_INVERT]      = lowOutputInvert;
      controlView[tlhc_pkg::BIT_OUTPUT_STATE]       = lowOutputState;
   end

   // data is latched at the setup edge and held through the access cycle
   always_ff @(posedge clk) begin
      if (reset) begin
         prdata <= tlhc_pkg::READ_ZERO;
      end else if (setupPhase && !pwrite) begin
         unique case (paddr)
            tlhc_pkg::OFF_TIMER_CONTROL: prdata <= controlView;
            tlhc_pkg::OFF_PERIOD:        prdata <= period;
            tlhc_pkg::OFF_COUNTER:       prdata <= counter;
            tlhc_pkg::OFF_GLOBAL_MODE: begin
               prdata <= tlhc_pkg::READ_ZERO;
               prdata[tlhc_pkg::BIT_OPMODE_HI:tlhc_pkg::BIT_OPMODE_LO] <= timerOperatingMode;
            end
            default:                     prdata <= tlhc_pkg::READ_ZERO;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // control register writes
   // ----------------------------------------------------------------
   logic writeControl;

   assign writeControl = writeDone && (paddr == tlhc_pkg::OFF_TIMER_CONTROL);

   // status bits 16 and 0 and reserved bits 15-10 take no write
   always_ff @(posedge clk) begin
      if (reset) begin
         lowInputGateEnable   <= 1'b0;
         lowClockSourceSelect <= 1'b0;
         lowEnablingMode      <= 2'b00;
         lowPulseWidth        <= 2'b00;
         lowClockPulseSelect  <= 1'b0;
         lowInputInvert       <= 1'b0;
         lowOutputInvert      <= 1'b0;
      end else if (writeControl) begin
         lowInputGateEnable   <= pwdata[tlhc_pkg::BIT_INPUT_GATE_ENABLE];
         lowClockSourceSelect <= pwdata[tlhc_pkg::BIT_CLOCK_SOURCE];
         lowEnablingMode      <=
            pwdata[tlhc_pkg::BIT_ENABLING_MODE_HI:tlhc_pkg::BIT_ENABLING_MODE_LO];
         lowPulseWidth        <=
            pwdata[tlhc_pkg::BIT_PULSE_WIDTH_HI:tlhc_pkg::BIT_PULSE_WIDTH_LO];
         lowClockPulseSelect  <= pwdata[tlhc_pkg::BIT_CLOCK_PULSE];
         lowInputInvert       <= pwdata[tlhc_pkg::BIT_INPUT_INVERT];
         lowOutputInvert      <= pwdata[tlhc_pkg::BIT_OUTPUT_INVERT];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         timerOperatingMode <= tlhc_pkg::RESET_OPMODE;
      end else if (writeDone && (paddr == tlhc_pkg::OFF_GLOBAL_MODE)) begin
         timerOperatingMode <= pwdata[tlhc_pkg::BIT_OPMODE_HI:tlhc_pkg::BIT_OPMODE_LO];
      end
   end

   // watchdog and dual modes belong to the global logic; this half reports
   // whether the single 64-bit mode is chosen and forces pulse mode in watchdog
   always_ff @(posedge clk) begin
      if (reset) begin
         gp64ModeSelect <= 1'b1;
      end else begin
         gp64ModeSelect <= (timerOperatingMode == tlhc_pkg::OPMODE_GP64);
      end
   end

   // period and counter are plain words; software stops the timer before
   // rewriting them, otherwise a reach can be missed
   always_ff @(posedge clk) begin
      if (reset) begin
         period <= tlhc_pkg::RESET_PERIOD;
      end else if (writeDone && (paddr == tlhc_pkg::OFF_PERIOD)) begin
         period <= pwdata;
      end
   end

   // upper half level, registered so bit 16 reads a stable value
   always_ff @(posedge clk) begin
      if (reset) begin
         upperOutputState <= 1'b0;
      end else begin
         upperOutputState <= upperTimerOutput;
      end
   end

   // ----------------------------------------------------------------
   // timer pin synchroniser and count enable
   // ----------------------------------------------------------------
   logic pinMeta;
   logic pinSync;
   logic pinLast;
   logic pinLevel;
   logic timerTick;

   // first stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (reset) begin
         pinMeta <= 1'b0;
         pinSync <= 1'b0;
      end else begin
         pinMeta <= timerInputPin;
         pinSync <= pinMeta;
      end
   end

   assign pinLevel = lowClockSourceSelect ? (pinSync ^ lowInputInvert) : pinSync;

   // pinLast resets low like the idle pin, so leaving reset gives no false edge
   always_ff @(posedge clk) begin
      if (reset) begin
         pinLast <= 1'b0;
      end else begin
         pinLast <= pinLevel;
      end
   end

   // the pin never clocks flops directly: a rising edge becomes one tick
   always_comb begin
      if (lowClockSourceSelect) begin
         timerTick = pinLevel && !pinLast;
      end else if (lowInputGateEnable) begin
         timerTick = pinSync;
      end else begin
         timerTick = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------
   logic        atPeriod;
   logic        running;
   logic        reachEvent;
   logic [31:0] next_counter;

   // exact compare: a counter written above the period runs on until it wraps
   assign atPeriod = (counter == period);

   // reserved encoding 11 counts as stopped, never as a mode
   always_comb begin
      unique case (lowEnablingMode)
         tlhc_pkg::TLHC_EN_ONE_SHOT:   running = !atPeriod;
         tlhc_pkg::TLHC_EN_CONTINUOUS: running = 1'b1;
         tlhc_pkg::TLHC_EN_DISABLED:   running = 1'b0;
         tlhc_pkg::TLHC_EN_RESERVED:   running = 1'b0;
      endcase
   end

   always_comb begin
      next_counter = counter;
      if (running && timerTick) begin
         if (atPeriod) begin
            next_counter = 32'h0000_0000;
         end else begin
            next_counter = counter + 32'h0000_0001;
         end
      end
   end

   // a reach is the increment that lands on the period, so one-shot fires once
   // and a period of zero fires only when a written count wraps back to zero
   assign reachEvent = running && timerTick && !atPeriod && (next_counter == period);

   always_ff @(posedge clk) begin
      if (reset) begin
         counter <= tlhc_pkg::RESET_COUNTER;
      end else if (writeDone && (paddr == tlhc_pkg::OFF_COUNTER)) begin
         counter <= pwdata;
      end else begin
         counter <= next_counter;
      end
   end

   // ----------------------------------------------------------------
   // output shaping
   // ----------------------------------------------------------------
   logic       pulseMode;
   logic [2:0] pulseLeft;
   logic       next_outputState;

   assign pulseMode = lowClockPulseSelect == 1'b0 ||
                      timerOperatingMode == tlhc_pkg::OPMODE_WATCHDOG;

   // width counts timer clock ticks, so a slow pin clock stretches the pulse
   always_ff @(posedge clk) begin
      if (reset) begin
         pulseLeft <= 3'h0;
      end else if (!pulseMode) begin
         pulseLeft <= 3'h0;
      end else if (reachEvent) begin
         pulseLeft <= {1'b0, lowPulseWidth} + 3'h1;
      end else if (timerTick && pulseLeft != 3'h0) begin
         pulseLeft <= pulseLeft - 3'h1;
      end
   end

   always_comb begin
      if (pulseMode) begin
         if (reachEvent) begin
            next_outputState = 1'b1;
         end else if (timerTick && pulseLeft == 3'h1) begin
            next_outputState = 1'b0;
         end else begin
            next_outputState = pulseLeft != 3'h0;
         end
      end else if (reachEvent) begin
         next_outputState = !lowOutputState;
      end else begin
         next_outputState = lowOutputState;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         lowOutputState <= 1'b0;
      end else begin
         lowOutputState <= next_outputState;
      end
   end

   // pin follows the status one cycle later so it stays a clean flop output
   always_ff @(posedge clk) begin
      if (reset) begin
         lowTimerOutputPin <= 1'b0;
      end else begin
         lowTimerOutputPin <= lowOutputState ^ lowOutputInvert;
      end
   end

endmodule

//--- tb/tlhc_timer_low_half_monitor.sv
// tlhc_timer_low_half_monitor: port-level assertions for the low timer half.
// assumes it is bound to tlhc_timer_low_half and sees only its ports.
module tlhc_timer_low_half_monitor (
   // clock and reset
   input wire logic        clk,
   input wire logic        reset,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   // pins
   input wire logic        upperTimerOutput,
   input wire logic        lowTimerOutputPin,
   input wire logic        gp64ModeSelect
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   property p_ready_after_setup;
      psel && !penable |=> pready;
   endproperty
   a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");

   property p_ready_single;
      pready |=> !pready;
   endproperty
   a_ready_single: assert property (p_ready_single) else $error("ready held too long");

   property p_err_with_ready;
      pslverr |-> pready && $past(psel && !penable);
   endproperty
   a_err_with_ready: assert property (p_err_with_ready) else $error("slverr outside access");

   property p_unmapped_zero;
      pslverr && !pwrite |-> prdata == 32'h0;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

   // control reads: the read word is captured at the setup edge
   property p_reserved_zero;
      pready && !pwrite && paddr == tlhc_pkg::OFF_TIMER_CONTROL |-> prdata[15:10] == 6'h00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

   property p_upper_state;
      pready && !pwrite && paddr == tlhc_pkg::OFF_TIMER_CONTROL
         |-> prdata[16] == $past(upperTimerOutput, 2);
   endproperty
   a_upper_state: assert property (p_upper_state) else $error("upper state wrong");

   // pin lags status by one cycle, as does the captured read word
   property p_pin_follows;
      pready && !pwrite && paddr == tlhc_pkg::OFF_TIMER_CONTROL
         |-> lowTimerOutputPin == (prdata[0] ^ prdata[1]);
   endproperty
   a_pin_follows: assert property (p_pin_follows) else $error("pin not status");

   property p_reset_quiet;
      $fell(reset) |-> !pready && !lowTimerOutputPin && gp64ModeSelect;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("bad reset state");
endmodule

bind tlhc_timer_low_half tlhc_timer_low_half_monitor tlhc_timer_low_half_monitor_inst (
   .clk(clk),
   .reset(reset),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pready(pready),
   .prdata(prdata),
   .pslverr(pslverr),
   .upperTimerOutput(upperTimerOutput),
   .lowTimerOutputPin(lowTimerOutputPin),
   .gp64ModeSelect(gp64ModeSelect)
);

//--- tb/tlhc_pin_model.sv
// tlhc_pin_model: far side of the timer pins and the upper half's level.
// assumes its tasks are called just after a rising edge of clk.
module tlhc_pin_model (
   // clock
   input wire logic clk,
   // pins
   output logic     timerPin,
   output logic     upperOut
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      timerPin = 1'h0;
      upperOut = 1'h0;
   end
   // flips every cycle so a stale status read cannot pass
   always @(posedge clk) begin
      upperOut <= ~upperOut;
   end
   task automatic hold(input logic lvl, input int n);
      timerPin <= lvl;
      repeat (n) @(posedge clk);
   endtask
endmodule

//--- tb/tlhc_timer_low_half_tb_top.sv
// tlhc_timer_low_half_tb_top: self-checking bench of the low timer half.
// assumes the pin model and the bound monitor are compiled before it.
module tlhc_timer_low_half_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic        clk, reset, psel, penable, pwrite, pready, pslverr, errSeen;
   logic        timerInputPin, upperTimerOutput, lowTimerOutputPin, gp64ModeSelect;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdVal, wdVal;
   int          err_total, cmp_count, seed, n, per;

   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end

   tlhc_timer_low_half tlhc_timer_low_half_inst (.clk(clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .timerInputPin(timerInputPin),
      .upperTimerOutput(upperTimerOutput), .lowTimerOutputPin(lowTimerOutputPin),
      .gp64ModeSelect(gp64ModeSelect));
   tlhc_pin_model tlhc_pin_model_inst (.clk(clk), .timerPin(timerInputPin),
      .upperOut(upperTimerOutput));

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      do @(posedge clk); while (pready !== 1'h1);
      rdVal = prdata;
      errSeen = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk);
   endtask

   task automatic rdCnt();
      xfer(1'h0, tlhc_pkg::OFF_COUNTER, 32'h0);
   endtask

   // mode bits cleared first so no count happens while period and count load
   task automatic cfg(input logic [31:0] p, input logic [31:0] c, input logic [31:0] ctl);
      xfer(1'h1, tlhc_pkg::OFF_TIMER_CONTROL, ctl & 32'hffff_ff3f);
      xfer(1'h1, tlhc_pkg::OFF_PERIOD, p);
      xfer(1'h1, tlhc_pkg::OFF_COUNTER, c);
      xfer(1'h1, tlhc_pkg::OFF_TIMER_CONTROL, ctl);
   endtask

   task automatic meas(input logic lvl, output int cnt);
      for (int i = 0; i < 64 && lowTimerOutputPin !== lvl; i++) @(posedge clk);
      cnt = 0;
      while (lowTimerOutputPin === lvl && cnt < 64) begin
         cnt++;
         @(posedge clk);
      end
   endtask

   task automatic end_sim();
      if (err_total == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      end_sim();
   end

   initial begin
      seed = 16680;
      err_total = 0;
      cmp_count = 0;
      reset = 1'h1;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (5) @(posedge clk);
      reset <= 1'h0;
      @(posedge clk);
      check("gp64 reset", {31'h0, gp64ModeSelect}, 32'h1);
      for (int a = 0; a < 16; a += 4) begin
         xfer(1'h0, 8'(a), 32'h0);
         check("reset value", rdVal & 32'h0000_fffe, 32'h0);
      end
      repeat (4) begin
         wdVal = $random(seed);
         xfer(1'h1, tlhc_pkg::OFF_TIMER_CONTROL, wdVal);
         xfer(1'h0, tlhc_pkg::OFF_TIMER_CONTROL, 32'h0);
         check("control", rdVal & 32'h0000_fffe, wdVal & 32'h0000_03fe);
      end
      xfer(1'h0, 8'h10, 32'h0);
      check("unmapped", rdVal, 32'h0);
      check("slverr", {31'h0, errSeen}, 32'h1);
      for (int m = 0; m < 2; m++) begin
         cfg(32'h10, 32'h5, 32'(m) * 32'hc0);
         repeat (10) @(posedge clk);
         rdCnt();
         check("held", rdVal, 32'h5);
      end
      cfg(32'h4, 32'h0, 32'h40);
      repeat (20) @(posedge clk);
      rdCnt();
      check("one-shot", rdVal, 32'h4);
      for (int k = 0; k < 8; k++) begin
         cfg(32'h8, 32'h0, 32'h80 | 32'((k & 3) << 4) | 32'((k >> 2) << 1));
         meas(k < 4, n);
         meas(k < 4, n);
         check("pulse width", 32'(n), 32'((k & 3) + 1));
      end
      repeat (2) begin
         per = 2 + ($random(seed) & 7);
         cfg(32'(per), 32'h0, 32'h88);
         meas(1'h1, n);
         meas(1'h1, n);
         check("clock half", 32'(n), 32'(per + 1));
         // read just after the output falls, so the monitor checks the pin against a low status
         xfer(1'h0, tlhc_pkg::OFF_TIMER_CONTROL, 32'h0);
         check("clock ctl", rdVal & 32'h0000_03fe, 32'h88);
         rdCnt();
         check("in range", {31'h0, rdVal <= 32'(per)}, 32'h1);
      end
      xfer(1'h1, tlhc_pkg::OFF_GLOBAL_MODE, 32'h8);
      // the select flop follows the mode register one edge later
      @(posedge clk);
      check("gp64 watchdog", {31'h0, gp64ModeSelect}, 32'h0);
      cfg(32'h8, 32'h0, 32'h88);
      meas(1'h1, n);
      meas(1'h1, n);
      check("forced pulse", 32'(n), 32'h1);
      xfer(1'h1, tlhc_pkg::OFF_GLOBAL_MODE, 32'h0);
      cfg(32'hffff, 32'h0, 32'h280);
      repeat (10) @(posedge clk);
      rdCnt();
      check("gated idle", rdVal, 32'h0);
      tlhc_pin_model_inst.hold(1'h1, 10);
      tlhc_pin_model_inst.hold(1'h0, 6);
      rdCnt();
      check("gated run", rdVal, 32'ha);
      cfg(32'hffff, 32'h0, 32'h80);
      repeat (20) @(posedge clk);
      rdCnt();
      check("ungated", {31'h0, rdVal >= 32'h14}, 32'h1);
      cfg(32'hffff, 32'h0, 32'h180);
      repeat (3) begin
         tlhc_pin_model_inst.hold(1'h1, 3);
         tlhc_pin_model_inst.hold(1'h0, 3);
      end
      rdCnt();
      check("pin edges", rdVal, 32'h3);
      cfg(32'hffff, 32'h0, 32'h184);
      tlhc_pin_model_inst.hold(1'h1, 6);
      rdCnt();
      check("inverted rise", rdVal, 32'h0);
      tlhc_pin_model_inst.hold(1'h0, 6);
      rdCnt();
      check("inverted fall", rdVal, 32'h1);
      end_sim();
   end
endmodule
